//--- logic/pump_motor_predriver_ctrl.sv
// Control and diagnostic logic for a pump motor high-side and recirculation pre-driver.
// Assumes a 25 MHz ref_clk, asynchronous pins and a host that writes and reads plain ports.
//
// Summary of operation
// R1: Gates follow commands; both high drives only the high-side gate.
// R2: Synchronised command levels are readable as status outputs.
// R3: Dead time between gate transitions is programmable in 24 steps.
// R4: Gates turn on only without watchdog reset, with enable, without faults.
// R5: Disabled pre-driver holds both gates low.
// R6: High-side gate turn-on timeout drops that gate, flags, rearms on command edge.
// R7: High-side gate turn-off timeout drops both gates, flags, clears enable.
// R8: Fault-cleared enable keeps gates off until host sets it; flags clear on read.
// R9: Flyback comparator held past 3 us after turn-off shuts down and flags.
// R10: FET turn-on timeout drops high-side gate, flags, rearms on command edge.
// R11: Two-bit threshold select picks one of four turn-on thresholds.
// R12: FET turn-off timeout drops both gates, flags, clears enable.
// R13: Recirculation turn-on timeout only flags; the gate keeps being driven.
// R14: Recirculation turn-off timeout drops both gates, flags, clears enable.
// R15: Off comparators watched all off time; masked only around command transitions.
// R16: Enable rising from low to high starts no masking.
// R17: Ground loss while enabled drops gates until active mode returns.
// R18: Persistent battery-low turns the pre-driver off until it clears.
// R19: Opposite gate waits the programmed dead time before turning on.
// R20: Comparators are deglitched; window timers start at gate command edges.
`include "pump_predrv_consts.svh"

module pump_motor_predriver_ctrl
    import pump_predrv_pkg::*;
#(
    parameter int SW_WINDOW_CYC = `SW_WINDOW_CYC,
    parameter int FILTER_CYC = `FILTER_CYC,
    parameter int BATT_DELAY_CYC = `BATT_DELAY_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic high_side_cmd_in,
    input wire logic recirc_cmd_in,
    input wire logic watchdogReset,
    input wire logic enableSet,
    input wire logic enableClear,
    input wire logic [`DEAD_SEL_W-1:0] deadTimeSel,
    input wire pump_predrv_pkg::threshold_sel_t thresholdSelIn,
    input wire logic faultRead,
    input wire logic highGateOnCmp,
    input wire logic high_side_off_comparator,
    input wire logic flybackCmp,
    input wire logic high_side_fet_monitor,
    input wire logic fet_off_comparator,
    input wire logic recircOnCmp,
    input wire logic recirc_off_comparator,
    input wire logic groundLoss,
    input wire logic activeMode,
    input wire logic batteryLow,
    output logic high_side_gate_out,
    output logic recirc_gate_out,
    output logic motorEnable,
    output logic highCmdStatus,
    output logic recircCmdStatus,
    output pump_predrv_pkg::threshold_sel_t drain_source_threshold_sel,
    output logic highOnFault,
    output logic highOffFault,
    output logic flybackFault,
    output logic fetOnFault,
    output logic fetOffFault,
    output logic recircOnFault,
    output logic recircOffFault
);

    // ==========================================================
    // Input synchronisation and filtering
    // ==========================================================
    localparam int NIN = 11;
    logic [NIN-1:0] rawIns;
    logic [NIN-1:0] cleanIns;
    logic highCmd, recircCmd, hgOn, hgOff, flyb, fetOn, fetOff, rgOn, rgOff, gndLoss, battLow;

    assign rawIns = {high_side_cmd_in, recirc_cmd_in, highGateOnCmp, high_side_off_comparator,
                     flybackCmp, high_side_fet_monitor, fet_off_comparator, recircOnCmp,
                     recirc_off_comparator, groundLoss, batteryLow};
    assign {highCmd, recircCmd, hgOn, hgOff, flyb, fetOn, fetOff, rgOn, rgOff, gndLoss,
            battLow} = cleanIns;

    // R20 comparator deglitch
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_in
            input_deglitch #(
                .FILTER_CYC((gi >= 9 || gi < 2) ? 1 : FILTER_CYC),
                .CNT_W(`TIMER_W)
            ) u_in (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .rawIn(rawIns[gi]),
                .cleanOut(cleanIns[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Fault detection state
    // ==========================================================
    logic highCmd_q, enable_q, groundLatch_q, hsBlock_q;
    logic [`TIMER_W-1:0] onTimer_q, offTimer_q, rOnTimer_q, rOffTimer_q, battTimer_q;
    logic onWin_q, offWin_q, rOnWin_q, rOffWin_q;
    logic [`TIMER_W-1:0] flyTimer_q;
    logic gateH_q, gateR_q;
    gate_state_t state_q, state_d;
    logic [`TIMER_W-1:0] dead_q, dead_d;
    logic [6:0] flags_q;
    logic hsRise, gateHRise, gateHFall, gateRRise, gateRFall;
    logic hgOnTo, hgOffTo, fetOnTo, fetOffTo, rgOnTo, rgOffTo, flyTo;
    logic shutdownEvt, hsDropEvt, battOff, allowOn;
    logic [6:0] flagSet;
    logic gateH_d, gateR_d;

    // Timeout test reused by every switching window.
    function automatic logic timedOut(input logic [`TIMER_W-1:0] cnt, input int limit);
        timedOut = cnt >= `TIMER_W'(limit);
    endfunction : timedOut

    assign hsRise = highCmd && !highCmd_q;
    assign gateHRise = gateH_d && !gateH_q;
    assign gateHFall = !gateH_d && gateH_q;
    assign gateRRise = gateR_d && !gateR_q;
    assign gateRFall = !gateR_d && gateR_q;

    // R6 high gate turn-on timeout
    assign hgOnTo = onWin_q && !hgOn && timedOut(onTimer_q, SW_WINDOW_CYC);
    // R10 FET turn-on timeout
    assign fetOnTo = onWin_q && !fetOn && timedOut(onTimer_q, SW_WINDOW_CYC);
    // R7 high gate turn-off timeout; R15 checked only outside the transition mask
    assign hgOffTo = offWin_q && !hgOff && timedOut(offTimer_q, SW_WINDOW_CYC);
    // R12 FET turn-off timeout
    assign fetOffTo = offWin_q && !fetOff && timedOut(offTimer_q, SW_WINDOW_CYC);
    // R13 recirculation turn-on timeout
    assign rgOnTo = rOnWin_q && !rgOn && timedOut(rOnTimer_q, SW_WINDOW_CYC);
    // R14 recirculation turn-off timeout
    assign rgOffTo = rOffWin_q && !rgOff && timedOut(rOffTimer_q, SW_WINDOW_CYC);
    // R9 flyback debounce after turn-off
    assign flyTo = !gateH_q && flyb && timedOut(flyTimer_q, FILTER_CYC);

    assign shutdownEvt = hgOffTo || fetOffTo || rgOffTo || flyTo;
    assign hsDropEvt = hgOnTo || fetOnTo;
    // R18 battery-low delay
    assign battOff = timedOut(battTimer_q, BATT_DELAY_CYC);
    // R4 gate permission; R17 ground latch blocks
    assign allowOn = !watchdogReset && enable_q && !groundLatch_q && !battOff && !shutdownEvt;
    assign flagSet = {hgOnTo, hgOffTo, flyTo, fetOnTo, fetOffTo, rgOnTo, rgOffTo};

    // ==========================================================
    // Non-overlap gate sequencer
    // ==========================================================
    // R1 command decode; R19 dead time before the opposite gate
    always_comb begin
        state_d = state_q;
        dead_d = dead_q;
        case (state_q)
            GATE_IDLE: begin
                if (highCmd)
                    state_d = GATE_HIGH;
                else if (recircCmd)
                    state_d = GATE_RECIRC;
            end
            GATE_HIGH: begin
                if (!highCmd) begin
                    state_d = GATE_DEAD;
                    // R3 24-step dead time
                    dead_d = `TIMER_W'((deadTimeSel >= `DEAD_SEL_W'(`DEAD_STEPS) ?
                        `DEAD_STEPS : deadTimeSel + 1) * `DEAD_STEP_CYC);
                end
            end
            GATE_RECIRC: begin
                // Either command change leaves through the dead time.
                if (highCmd || !recircCmd) begin
                    state_d = GATE_DEAD;
                    dead_d = `TIMER_W'((deadTimeSel >= `DEAD_SEL_W'(`DEAD_STEPS) ?
                        `DEAD_STEPS : deadTimeSel + 1) * `DEAD_STEP_CYC);
                end
            end
            GATE_DEAD: begin
                if (dead_q <= `TIMER_W'(1))
                    state_d = GATE_IDLE;
                else
                    dead_d = dead_q - 1'b1;
            end
            default: state_d = GATE_IDLE;
        endcase
    end

    // R5 disabled holds gates low; R6 high-side drop until rearm
    assign gateH_d = allowOn && !hsBlock_q && !hsDropEvt && state_q == GATE_HIGH;
    // R13 recirculation gate stays driven on its own turn-on fault
    assign gateR_d = allowOn && state_q == GATE_RECIRC;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= GATE_IDLE;
            dead_q <= '0;
            gateH_q <= 1'b0;
            gateR_q <= 1'b0;
            highCmd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            dead_q <= dead_d;
            gateH_q <= gateH_d;
            gateR_q <= gateR_d;
            highCmd_q <= highCmd;
        end
    end

    // ==========================================================
    // Switching window timers
    // ==========================================================
    // R20 timers start at gate edges; R16 enable edge alone never restarts a mask
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            onTimer_q <= '0;
            offTimer_q <= '0;
            rOnTimer_q <= '0;
            rOffTimer_q <= '0;
            onWin_q <= 1'b0;
            offWin_q <= 1'b0;
            rOnWin_q <= 1'b0;
            rOffWin_q <= 1'b0;
        end else begin
            onTimer_q <= gateHRise ? '0 : (timedOut(onTimer_q, SW_WINDOW_CYC) ? onTimer_q
                                                                  : onTimer_q + 1'b1);
            offTimer_q <= gateHFall ? '0 : (timedOut(offTimer_q, SW_WINDOW_CYC) ? offTimer_q
                                                                   : offTimer_q + 1'b1);
            rOnTimer_q <= gateRRise ? '0 : (timedOut(rOnTimer_q, SW_WINDOW_CYC) ? rOnTimer_q
                                                                   : rOnTimer_q + 1'b1);
            rOffTimer_q <= gateRFall ? '0 : (timedOut(rOffTimer_q, SW_WINDOW_CYC) ? rOffTimer_q
                                                                     : rOffTimer_q + 1'b1);
            // On windows check once per edge; off windows stay armed through the off state.
            onWin_q <= gateHRise || (onWin_q && gateH_q && !hgOnTo && !fetOnTo);
            offWin_q <= gateHFall || (offWin_q && !gateH_q);
            rOnWin_q <= gateRRise || (rOnWin_q && gateR_q && !rgOnTo);
            rOffWin_q <= gateRFall || (rOffWin_q && !gateR_q);
        end
    end

    // R15 flyback watched through the whole off state.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flyTimer_q <= '0;
            battTimer_q <= '0;
        end else begin
            flyTimer_q <= (gateH_q || !flyb || !offWin_q) ? '0 :
                          (timedOut(flyTimer_q, FILTER_CYC) ? flyTimer_q : flyTimer_q + 1'b1);
            battTimer_q <= !battLow ? '0 : (battOff ? battTimer_q : battTimer_q + 1'b1);
        end
    end

    // ==========================================================
    // Enable, latches and status
    // ==========================================================
    // R8 enable cleared by fault until host sets it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
            hsBlock_q <= 1'b0;
            groundLatch_q <= 1'b0;
            flags_q <= '0;
        end else begin
            if (shutdownEvt)
                enable_q <= 1'b0;
            else if (enableSet)
                enable_q <= 1'b1;
            else if (enableClear)
                enable_q <= 1'b0;
            // R6 rearm on next rising command edge; R10 same rearm
            if (hsDropEvt)
                hsBlock_q <= 1'b1;
            else if (hsRise)
                hsBlock_q <= 1'b0;
            // R17 ground loss latch
            if (gndLoss && enable_q)
                groundLatch_q <= 1'b1;
            else if (activeMode && !gndLoss)
                groundLatch_q <= 1'b0;
            // R8 clear on read, a new event wins
            flags_q <= (faultRead ? '0 : flags_q) | flagSet;
        end
    end

    // R2 command status; R11 threshold select
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            highCmdStatus <= 1'b0;
            recircCmdStatus <= 1'b0;
            drain_source_threshold_sel <= '0;
            high_side_gate_out <= 1'b0;
            recirc_gate_out <= 1'b0;
            motorEnable <= 1'b0;
            {highOnFault, highOffFault, flybackFault, fetOnFault, fetOffFault,
             recircOnFault, recircOffFault} <= '0;
        end else begin
            highCmdStatus <= highCmd;
            recircCmdStatus <= recircCmd;
            drain_source_threshold_sel <= thresholdSelIn;
            high_side_gate_out <= gateH_d;
            recirc_gate_out <= gateR_d;
            motorEnable <= enable_q;
            {highOnFault, highOffFault, flybackFault, fetOnFault, fetOffFault,
             recircOnFault, recircOffFault} <= (faultRead ? '0 : flags_q) | flagSet;
        end
    end

endmodule : pump_motor_predriver_ctrl

//--- logic/pump_predrv_consts.svh
// Timing and field constants for the pump motor pre-driver control logic.
// Assumes a 25 MHz reference clock; all counts are derived from it.
`ifndef PUMP_PREDRV_CONSTS_SVH
`define PUMP_PREDRV_CONSTS_SVH

// Reference clock period in picoseconds.
`define CLK_PERIOD_PS 40000
// Dead time step in nanoseconds, and number of steps.
`define DEAD_STEP_NS 250
`define DEAD_STEPS 24
// Dead time step in cycles, rounded up.
`define DEAD_STEP_CYC ((`DEAD_STEP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Switching window in nanoseconds; a longest time, so rounded down.
`define SW_WINDOW_NS 6000
`define SW_WINDOW_CYC ((`SW_WINDOW_NS * 1000) / `CLK_PERIOD_PS)
// Comparator filter and flyback debounce time in nanoseconds; a least time, rounded up.
`define FILTER_NS 3000
`define FILTER_CYC ((`FILTER_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Battery-low disable delay in nanoseconds (plain default).
`define BATT_DELAY_NS 10000
`define BATT_DELAY_CYC ((`BATT_DELAY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Widths.
`define DEAD_SEL_W 5
`define THR_SEL_W 2
`define TIMER_W 10

`endif

//--- logic/pump_predrv_pkg.sv
// Types shared by the pump motor pre-driver control logic.
// Assumes the constants header is on the include path.
package pump_predrv_pkg;

    // Gate sequencing state of the non-overlap controller.
    typedef enum logic [1:0] {
        GATE_IDLE,
        GATE_HIGH,
        GATE_RECIRC,
        GATE_DEAD
    } gate_state_t;

    // Selected drain-source threshold code.
    typedef logic [1:0] threshold_sel_t;

endpackage : pump_predrv_pkg

//--- logic/input_deglitch.sv
// Three-flop synchroniser with an agreement filter and a hold-time deglitcher.
// Assumes the input is asynchronous to ref_clk.
module input_deglitch #(
    parameter int FILTER_CYC = 1,
    parameter int CNT_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rawIn,
    output logic cleanOut
);

    logic syncA_q;
    logic syncB_q;
    logic syncC_q;
    logic agree;
    logic [CNT_W-1:0] holdCnt_q;
    logic [CNT_W-1:0] holdCnt_d;
    logic clean_d;

    // The first stage is read only by the second stage.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_q <= 1'b0;
            syncB_q <= 1'b0;
            syncC_q <= 1'b0;
        end else begin
            syncA_q <= rawIn;
            syncB_q <= syncA_q;
            syncC_q <= syncB_q;
        end
    end

    // A change only counts when the last two stages agree and differ from the output.
    assign agree = (syncB_q == syncC_q) && (syncC_q != cleanOut);
    assign holdCnt_d = agree ? holdCnt_q + 1'b1 : '0;
    assign clean_d = (agree && holdCnt_q >= CNT_W'(FILTER_CYC - 1)) ? syncC_q : cleanOut;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            holdCnt_q <= '0;
            cleanOut <= 1'b0;
        end else begin
            holdCnt_q <= (clean_d != cleanOut) ? '0 : holdCnt_d;
            cleanOut <= clean_d;
        end
    end

endmodule : input_deglitch

//--- dv/pump_predrv_assertions.sv
// Concurrent checks on the ports of the pump motor pre-driver control block.
// Assumes one ref_clk domain with the active-low asynchronous reset rst_n.
module pump_predrv_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic high_side_cmd_in,
    input wire logic recirc_cmd_in,
    input wire logic watchdogReset,
    input wire logic enableSet,
    input wire logic enableClear,
    input wire pump_predrv_pkg::threshold_sel_t thresholdSelIn,
    input wire logic faultRead,
    input wire logic high_side_gate_out,
    input wire logic recirc_gate_out,
    input wire logic motorEnable,
    input wire logic highCmdStatus,
    input wire logic recircCmdStatus,
    input wire pump_predrv_pkg::threshold_sel_t drain_source_threshold_sel,
    input wire logic highOnFault,
    input wire logic highOffFault,
    input wire logic flybackFault,
    input wire logic fetOnFault,
    input wire logic fetOffFault,
    input wire logic recircOnFault,
    input wire logic recircOffFault
);
    import pump_predrv_pkg::*;
    // =========================================================================
    // Helpers
    logic [6:0] flagsV;
    logic gatesOff;
    // Flags in the order of the bench's stall bits; bits 6:3 are the shutdown faults.
    assign flagsV = {flybackFault, recircOffFault, fetOffFault, highOffFault,
                     recircOnFault, fetOnFault, highOnFault};
    assign gatesOff = !high_side_gate_out && !recirc_gate_out;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Commands held long enough to cross the synchronisers.
    sequence cmdSteady_s;
        ($stable(high_side_cmd_in) && $stable(recirc_cmd_in)) [*8];
    endsequence
    // =========================================================================
    // Properties
    chk_gate_exclusive: assert property (!(high_side_gate_out && recirc_gate_out))
        else $error("Both gates on together");
    chk_cmd_status: assert property (cmdSteady_s |-> highCmdStatus == high_side_cmd_in
        && recircCmdStatus == recirc_cmd_in) else $error("Command status differs from pins");
    chk_dead_rc2hi: assert property ($fell(recirc_gate_out) |-> !high_side_gate_out [*7])
        else $error("High-side gate rose inside dead time");
    chk_dead_hi2rc: assert property ($fell(high_side_gate_out) |-> !recirc_gate_out [*7])
        else $error("Recirculation gate rose inside dead time");
    chk_wdog_block: assert property (watchdogReset && $past(watchdogReset) |-> gatesOff)
        else $error("Gate on during watchdog reset");
    chk_disabled_low: assert property (!motorEnable && !$past(motorEnable) |-> gatesOff)
        else $error("Gate on while disabled");
    chk_on_drop: assert property ($rose(highOnFault || fetOnFault) |-> ##[0:2]
        !high_side_gate_out) else $error("High-side gate kept after turn-on fault");
    chk_off_shutdown: assert property ($rose(|flagsV[6:3]) |-> ##[0:2]
        (!motorEnable && gatesOff)) else $error("No shutdown after off fault");
    chk_flags_latched: assert property (!faultRead && !$past(faultRead) |=>
        (flagsV & $past(flagsV)) == $past(flagsV)) else $error("Fault flag lost unread");
    chk_read_clears: assert property (faultRead |-> ##[1:3] flagsV == 7'h00)
        else $error("Fault flags not cleared by read");
    chk_enable_set: assert property (enableSet && !enableClear && flagsV[6:3] == 4'h0
        |-> ##[1:2] motorEnable) else $error("Enable not set");
    chk_thr_copy: assert property ($past(rst_n) |->
        drain_source_threshold_sel == $past(thresholdSelIn)) else $error("Threshold copy wrong");
    chk_recirc_keep: assert property ($rose(recircOnFault) && motorEnable && recirc_cmd_in
        |-> recirc_gate_out [*4]) else $error("Recirculation gate dropped on turn-on fault");
endmodule : pump_predrv_assertions

bind pump_motor_predriver_ctrl pump_predrv_assertions chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .high_side_cmd_in(high_side_cmd_in),
    .recirc_cmd_in(recirc_cmd_in), .watchdogReset(watchdogReset), .enableSet(enableSet),
    .enableClear(enableClear), .thresholdSelIn(thresholdSelIn), .faultRead(faultRead),
    .high_side_gate_out(high_side_gate_out), .recirc_gate_out(recirc_gate_out),
    .motorEnable(motorEnable), .highCmdStatus(highCmdStatus), .recircCmdStatus(recircCmdStatus),
    .drain_source_threshold_sel(drain_source_threshold_sel), .highOnFault(highOnFault),
    .highOffFault(highOffFault), .flybackFault(flybackFault), .fetOnFault(fetOnFault),
    .fetOffFault(fetOffFault), .recircOnFault(recircOnFault), .recircOffFault(recircOffFault));

//--- dv/fet_pair_model.sv
// Behavioural model of the two external FETs and their diagnostic comparators.
// Assumes gate levels from the control block; a stall bit holds one comparator back.
module fet_pair_model (
    input wire logic ref_clk,
    input wire logic hiGate,
    input wire logic rcGate,
    input wire logic slow,
    input wire logic [6:0] stall,
    output logic [6:0] cmp
);
    timeunit 1ns;
    timeprecision 100ps;
    // =========================================================================
    // FET response
    logic [7:0] hiSh = 8'h00;
    logic [7:0] rcSh = 8'h00;
    logic hiNow;
    logic rcNow;
    // Gate charge delay; the slow tap still lands inside the switching window.
    always @(posedge ref_clk) begin
        hiSh <= {hiSh[6:0], hiGate};
        rcSh <= {rcSh[6:0], rcGate};
    end
    assign hiNow = slow ? hiSh[5] : hiSh[1];
    assign rcNow = slow ? rcSh[5] : rcSh[1];
    // comparator levels, flyback only when commanded broken.
    assign cmp = {!hiNow & stall[6], !rcNow & !stall[5], !hiNow & !stall[4], !hiNow & !stall[3],
                  rcNow & !stall[2], hiNow & !stall[1], hiNow & !stall[0]};
endmodule : fet_pair_model

//--- dv/tb_pump_motor_predriver_ctrl.sv
// Self-checking bench for the pump motor pre-driver control block.
// Assumes the package, constants header, model and checker are compiled first.
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module tb_pump_motor_predriver_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import pump_predrv_pkg::*;
    // =========================================================================
    // Signals
    logic ref_clk, rst_n, hi, rc, wdog, enSet, enClr, rd, gnd, act, batt, slow;
    logic [4:0] dts;
    threshold_sel_t thr, thrOut;
    logic [6:0] stall;
    wire logic [6:0] flg, cmp;
    wire logic hg, rg, menb, hs, rs;
    int err_total, cmp_count, i, b, n, cnt, expCyc;
    logic [3:0] rows [5] = '{4'h0, 4'ha, 4'h5, 4'he, 4'h0};
    int codes [3] = '{0, 23, 31};
    // Short window and filter counts keep the run brief.
    pump_motor_predriver_ctrl #(.SW_WINDOW_CYC(20), .FILTER_CYC(4), .BATT_DELAY_CYC(5)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .high_side_cmd_in(hi), .recirc_cmd_in(rc),
        .watchdogReset(wdog), .enableSet(enSet), .enableClear(enClr), .deadTimeSel(dts),
        .thresholdSelIn(thr), .faultRead(rd), .highGateOnCmp(cmp[0]),
        .high_side_fet_monitor(cmp[1]), .recircOnCmp(cmp[2]), .high_side_off_comparator(cmp[3]),
        .fet_off_comparator(cmp[4]), .recirc_off_comparator(cmp[5]), .flybackCmp(cmp[6]),
        .groundLoss(gnd), .activeMode(act), .batteryLow(batt), .high_side_gate_out(hg),
        .recirc_gate_out(rg), .motorEnable(menb), .highCmdStatus(hs), .recircCmdStatus(rs),
        .drain_source_threshold_sel(thrOut), .highOnFault(flg[0]), .fetOnFault(flg[1]),
        .recircOnFault(flg[2]), .highOffFault(flg[3]), .fetOffFault(flg[4]),
        .recircOffFault(flg[5]), .flybackFault(flg[6]));
    fet_pair_model fets (.ref_clk(ref_clk), .hiGate(hg), .rcGate(rg), .slow(slow),
        .stall(stall), .cmp(cmp));
    // =========================================================================
    // Clock, tasks and watchdog
    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Inputs always move 2 ns after the rising edge, clear of sampling.
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask : cyc
    task automatic readFlags();
        rd = 1'h1; cyc(1); rd = 1'h0; cyc(3);
    endtask : readFlags
    task automatic setEn();
        enSet = 1'h1; cyc(1); enSet = 1'h0; cyc(4);
    endtask : setEn
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    // A hang is cut off well past the few thousand cycles the tests need.
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        $display("ERROR watchdog exp done got hang");
        close_out();
    end
    // =========================================================================
    // Tests
    initial begin
        {hi, rc, wdog, enSet, enClr, rd, gnd, batt, slow} = '0;
        act = 1'h1; dts = 5'h00; thr = 2'h0; stall = 7'h00; rst_n = 1'h0;
        cyc(4);
        `CHK("reset", 10'h000, {hg, rg, menb, flg})
        cyc(2); rst_n = 1'h1; cyc(2); setEn();
        `CHK("enable", 1'h1, menb)
        // Truth table rows, prompt and slow FETs in turn.
        for (i = 0; i < 5; i++) begin
            {hi, rc} = rows[i][3:2]; slow = i[0]; cyc(60);
            `CHK("gates", rows[i][1:0], {hg, rg})
            `CHK("status", rows[i][3:2], {hs, rs})
        end
        for (i = 0; i < 4; i++) begin
            thr = i[1:0]; cyc(2);
            `CHK("thrSel", i[1:0], thrOut)
        end
        // Dead time at the smallest, largest and clamped codes.
        foreach (codes[k]) begin
            dts = codes[k][4:0]; rc = 1'h1; hi = 1'h0; cyc(300); hi = 1'h1;
            for (n = 0; n < 60 && rg !== 1'h0; n++) cyc(1);
            for (cnt = 0; cnt < 400 && hg !== 1'h1; cnt++) cyc(1);
            expCyc = ((codes[k] > 23) ? 24 : codes[k] + 1) * 7;
            `CHK("dead", 1'h1, (cnt >= expCyc - 1) && (cnt <= expCyc + 3))
        end
        {hi, rc} = 2'h2; dts = 5'h00; cyc(300);
        // Watchdog, host clear, ground loss and battery low with the command held.
        wdog = 1'h1; cyc(3);
        `CHK("wdog", 1'h0, hg)
        wdog = 1'h0; cyc(40);
        `CHK("wdogEnd", 1'h1, hg)
        enClr = 1'h1; cyc(1); enClr = 1'h0; cyc(4);
        `CHK("clear", 2'h0, {menb, hg})
        setEn(); cyc(40); gnd = 1'h1; act = 1'h0; cyc(8);
        `CHK("gndLoss", 1'h0, hg)
        gnd = 1'h0; cyc(20);
        `CHK("gndHold", 1'h0, hg)
        act = 1'h1; cyc(40);
        `CHK("gndBack", 1'h1, hg)
        batt = 1'h1; cyc(20);
        `CHK("battLow", 1'h0, hg)
        batt = 1'h0; cyc(40);
        `CHK("battBack", 1'h1, hg)
        hi = 1'h0; cyc(40);
        // Turn-on timeouts of the gate and the FET monitor.
        for (b = 0; b < 2; b++) begin
            stall[b] = 1'h1; hi = 1'h1; cyc(60);
            `CHK("onTrip", 3'h5, {flg[b], hg, menb})
            hi = 1'h0; stall = 7'h00; cyc(30); readFlags();
            `CHK("onRead", 1'h0, flg[b])
            hi = 1'h1; cyc(40);
            `CHK("rearm", 1'h1, hg)
            hi = 1'h0; cyc(40);
        end
        stall[2] = 1'h1; rc = 1'h1; cyc(60);
        `CHK("rcOnTrip", 2'h3, {flg[2], rg})
        rc = 1'h0; stall = 7'h00; cyc(40); readFlags();
        // Turn-off timeouts and open flyback all shut down and clear enable.
        for (b = 3; b < 7; b++) begin
            if (b == 5) rc = 1'h1;
            else hi = 1'h1;
            cyc(40); stall[b] = 1'h1; {hi, rc} = 2'h0; cyc(60);
            `CHK("offTrip", 4'h8, {flg[b], menb, hg, rg})
            stall = 7'h00; cyc(10); readFlags();
            `CHK("offRead", 1'h0, flg[b])
            hi = 1'h1; cyc(40);
            `CHK("held", 1'h0, hg)
            hi = 1'h0; cyc(40); setEn();
        end
        close_out();
    end
endmodule : tb_pump_motor_predriver_ctrl
